/* File: pkg/irq_flags_pkg.sv */
// Constants and types shared by the peripheral flag and enable block
`default_nettype none
package irq_flags_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned IDX_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ENABLE_A = 12'hF9D;
  localparam logic [IDX_W-1:0] IDX_FLAGS_A = 12'hF9E;
  localparam logic [IDX_W-1:0] IDX_ENABLE_B = 12'hFA0;
  localparam logic [IDX_W-1:0] IDX_FLAGS_B = 12'hFA1;
  localparam logic [IDX_W-1:0] IDX_ENABLE_C = 12'hFA3;
  localparam logic [IDX_W-1:0] IDX_FLAGS_C = 12'hFA4;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 12'hFB0;

  localparam logic [REG_W-1:0] RST_ENABLE = 8'h00;
  localparam logic [REG_W-1:0] RST_FLAGS = 8'h00;
  localparam logic [1:0] RST_CONTROL = 2'h0;

  // First register group
  localparam int unsigned A_PARALLEL = 7;
  localparam int unsigned A_CONVERTER = 6;
  localparam int unsigned A_UART_RX = 5;
  localparam int unsigned A_UART_TX = 4;
  localparam int unsigned A_SERIAL_DONE = 3;
  localparam int unsigned A_CAPCOMP = 2;
  localparam int unsigned A_TIMER2 = 1;
  localparam int unsigned A_TIMER1 = 0;
  // Second register group
  localparam int unsigned B_CLOCK_FAIL = 7;
  localparam int unsigned B_COMPARATOR_B = 6;
  localparam int unsigned B_COMPARATOR_A = 5;
  localparam int unsigned B_UNUSED = 4;
  localparam int unsigned B_COLLISION = 3;
  localparam int unsigned B_VOLTAGE = 2;
  localparam int unsigned B_TIMER3 = 1;
  localparam int unsigned B_CAPCOMP = 0;
  // Third register group
  localparam int unsigned C_SERIAL_DONE = 7;
  localparam int unsigned C_COLLISION = 6;
  localparam int unsigned C_UART_RX = 5;
  localparam int unsigned C_UART_TX = 4;
  localparam int unsigned C_TIMER4 = 3;
  localparam int unsigned C_CHARGE_TIME = 2;
  localparam int unsigned C_TIMER3_GATE = 1;
  localparam int unsigned C_RTC = 0;
  // Control register fields
  localparam int unsigned CTL_GROUP_EN = 0;
  localparam int unsigned CTL_PRIORITY = 1;

  // Implemented and software-writable bits per group
  localparam logic [REG_W-1:0] IMPL_A_FULL = 8'hFF;
  localparam logic [REG_W-1:0] IMPL_A_SMALL = 8'h7F;
  localparam logic [REG_W-1:0] IMPL_B = 8'hEF;
  localparam logic [REG_W-1:0] IMPL_C = 8'hFF;
  localparam logic [REG_W-1:0] SWCLR_A = 8'hCF;
  localparam logic [REG_W-1:0] SWCLR_B = 8'hEF;
  localparam logic [REG_W-1:0] SWCLR_C = 8'hCF;

  typedef enum logic [1:0] {
    CC_OFF = 2'h0,
    CC_CAPTURE = 2'h1,
    CC_COMPARE = 2'h3,
    CC_PWM = 2'h2
  } capcomp_mode_t;

  // One-cycle event pulses from peripherals on the system clock
  typedef struct packed {
    logic parallel_port;
    logic converter_done;
    logic serial_a_done;
    logic capcomp_a;
    logic timer2_match;
    logic timer1_overflow;
  } events_a_t;

  typedef struct packed {
    logic clock_fail;
    logic serial_a_collision;
    logic voltage_trip;
    logic timer3_overflow;
    logic capcomp_b;
  } events_b_t;

  typedef struct packed {
    logic serial_b_done;
    logic serial_b_collision;
    logic timer4_match;
    logic charge_time;
    logic timer3_gate;
    logic rtc_event;
  } events_c_t;
endpackage
`default_nettype wire

/* File: verilog/periph_irq_flags.sv */
// Peripheral interrupt flags, enables and request logic with APB access
// Operation
// - Timer2 match sets sticky first-group bit 1
// - Timer1 overflow sets sticky first-group bit 0
// - Small package drops parallel port bit 7
// - Clock fail sets sticky second-group bit 7
// - Comparator output change sets bits 6, 5
// - Second-group bit 4 reads zero, ignores writes
// - Serial bus collisions set sticky flags
// - Voltage trip sets sticky second-group bit 2
// - Timer3 overflow sets sticky second-group bit 1
// - Capcomp b flags capture/compare, never pulse-width
// - Serial b completion sets sticky third bit 7
// - Uart b receive flag follows buffer full
// - Uart b transmit flag follows buffer empty
// - Timer4 match sets sticky third-group bit 3
// - Charge-time event sets sticky third bit 2
// - Timer3 gate event sets sticky bit 1
// - Real-time clock event sets sticky bit 0
// - Group enable off blocks all peripheral requests
// - First enable register bit layout as listed
// - Second enable bits mirror second flag positions
// - Flags set regardless of any enable
// - Priority mode: group enable still gates every request
`default_nettype none
module periph_irq_flags
  import irq_flags_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire events_a_t EV_A,
  input wire logic UART_A_RX_FULL,
  input wire logic UART_A_TX_EMPTY,
  input wire capcomp_mode_t CAPCOMP_A_MODE,
  input wire events_b_t EV_B,
  input wire logic [1:0] CMP_OUT,
  input wire capcomp_mode_t CAPCOMP_B_MODE,
  input wire events_c_t EV_C,
  input wire logic UART_B_RX_FULL,
  input wire logic UART_B_TX_EMPTY,
  output logic PERIPH_IRQ,
  output logic PRIORITY_MODE
);

  localparam logic [REG_W-1:0] IMPL_A = SMALL_PACKAGE ? IMPL_A_SMALL
                                                      : IMPL_A_FULL;

  // Sticky flags: write stores data, an event in the same cycle wins
  function automatic logic [REG_W-1:0] flag_next(
    input logic [REG_W-1:0] cur,
    input logic wr,
    input logic [REG_W-1:0] wdata,
    input logic [REG_W-1:0] set,
    input logic [REG_W-1:0] swmask,
    input logic [REG_W-1:0] level,
    input logic [REG_W-1:0] impl
  );
    logic [REG_W-1:0] kept;
    kept = wr ? wdata : cur;
    return (((kept | set) & swmask) | (level & ~swmask)) & impl;
  endfunction

  logic [REG_W-1:0] enable_a_q, enable_a_d;
  logic [REG_W-1:0] enable_b_q, enable_b_d;
  logic [REG_W-1:0] enable_c_q, enable_c_d;
  logic [REG_W-1:0] flags_a_q, flags_a_d;
  logic [REG_W-1:0] flags_b_q, flags_b_d;
  logic [REG_W-1:0] flags_c_q, flags_c_d;
  logic [1:0] control_q, control_d;
  logic [1:0] cmp_s1_q, cmp_s2_q, cmp_prev_q;
  logic ready_q, err_q, irq_q;
  logic [DATA_W-1:0] rdata_q;

  // APB decode
  wire logic setup = PSEL & ~PENABLE;
  wire logic wr_now = PSEL & PENABLE & PWRITE & ready_q & PSTRB[0];
  wire logic aligned = (PADDR[1:0] == 2'h0)
                       & (PADDR[ADDR_W-1:IDX_W+2] == '0);
  wire logic [IDX_W-1:0] idx = PADDR[IDX_W+1:2];
  wire logic sel_en_a = aligned & (idx == IDX_ENABLE_A);
  wire logic sel_fl_a = aligned & (idx == IDX_FLAGS_A);
  wire logic sel_en_b = aligned & (idx == IDX_ENABLE_B);
  wire logic sel_fl_b = aligned & (idx == IDX_FLAGS_B);
  wire logic sel_en_c = aligned & (idx == IDX_ENABLE_C);
  wire logic sel_fl_c = aligned & (idx == IDX_FLAGS_C);
  wire logic sel_ctl = aligned & (idx == IDX_CONTROL);
  wire logic mapped = sel_en_a | sel_fl_a | sel_en_b | sel_fl_b
                      | sel_en_c | sel_fl_c | sel_ctl;
  wire logic [REG_W-1:0] wbyte = PWDATA[REG_W-1:0];

  wire logic [REG_W-1:0] rd_byte =
      sel_en_a ? enable_a_q :
      sel_fl_a ? flags_a_q :
      sel_en_b ? enable_b_q :
      sel_fl_b ? flags_b_q :
      sel_en_c ? enable_c_q :
      sel_fl_c ? flags_c_q :
      sel_ctl ? {6'h00, control_q} : 8'h00;

  // Comparator change detect on the synchronised outputs
  wire logic [1:0] cmp_change = cmp_s2_q ^ cmp_prev_q;

  // Capture/compare units flag only in capture or compare mode
  wire logic cc_a_ok = (CAPCOMP_A_MODE == CC_CAPTURE)
                       | (CAPCOMP_A_MODE == CC_COMPARE);
  wire logic cc_b_ok = (CAPCOMP_B_MODE == CC_CAPTURE)
                       | (CAPCOMP_B_MODE == CC_COMPARE);

  // Event vectors at flag positions; enables never gate them
  wire logic [REG_W-1:0] set_a = {
    EV_A.parallel_port,
    EV_A.converter_done,
    2'h0,
    EV_A.serial_a_done,
    EV_A.capcomp_a & cc_a_ok,
    EV_A.timer2_match,
    EV_A.timer1_overflow
  };
  wire logic [REG_W-1:0] set_b = {
    EV_B.clock_fail,
    cmp_change[1],
    cmp_change[0],
    1'b0,
    EV_B.serial_a_collision,
    EV_B.voltage_trip,
    EV_B.timer3_overflow,
    EV_B.capcomp_b & cc_b_ok
  };
  wire logic [REG_W-1:0] set_c = {
    EV_C.serial_b_done,
    EV_C.serial_b_collision,
    2'h0,
    EV_C.timer4_match,
    EV_C.charge_time,
    EV_C.timer3_gate,
    EV_C.rtc_event
  };
  // Buffer-state bits follow the uart levels, writes ignored
  wire logic [REG_W-1:0] lvl_a = {2'h0, UART_A_RX_FULL, UART_A_TX_EMPTY,
                                  4'h0};
  wire logic [REG_W-1:0] lvl_c = {2'h0, UART_B_RX_FULL,
                                  UART_B_TX_EMPTY, 4'h0};

  assign flags_a_d = flag_next(flags_a_q, wr_now & sel_fl_a, wbyte,
                               set_a, SWCLR_A, lvl_a, IMPL_A);
  assign flags_b_d = flag_next(flags_b_q, wr_now & sel_fl_b, wbyte,
                               set_b, SWCLR_B, 8'h00, IMPL_B);
  assign flags_c_d = flag_next(flags_c_q, wr_now & sel_fl_c, wbyte,
                               set_c, SWCLR_C, lvl_c, IMPL_C);

  // Enable layouts match flag layouts bit for bit
  assign enable_a_d = (wr_now & sel_en_a) ? (wbyte & IMPL_A)
                                          : enable_a_q;
  assign enable_b_d = (wr_now & sel_en_b) ? (wbyte & IMPL_B)
                                          : enable_b_q;
  assign enable_c_d = (wr_now & sel_en_c) ? wbyte : enable_c_q;
  assign control_d = (wr_now & sel_ctl) ? wbyte[1:0] : control_q;

  // Priorities live elsewhere, so in both modes the group enable
  // gates the whole request handed to the core
  wire logic group_en = control_q[CTL_GROUP_EN];
  wire logic any_pending = |(flags_a_q & enable_a_q)
                           | |(flags_b_q & enable_b_q)
                           | |(flags_c_q & enable_c_q);
  wire logic irq_d = any_pending & group_en;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cmp_s1_q <= 2'h0;
      cmp_s2_q <= 2'h0;
      cmp_prev_q <= 2'h0;
    end else begin
      cmp_s1_q <= CMP_OUT;
      cmp_s2_q <= cmp_s1_q;
      cmp_prev_q <= cmp_s2_q;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      enable_a_q <= RST_ENABLE;
      enable_b_q <= RST_ENABLE;
      enable_c_q <= RST_ENABLE;
      flags_a_q <= RST_FLAGS;
      flags_b_q <= RST_FLAGS;
      flags_c_q <= RST_FLAGS;
      control_q <= RST_CONTROL;
    end else begin
      enable_a_q <= enable_a_d;
      enable_b_q <= enable_b_d;
      enable_c_q <= enable_c_d;
      flags_a_q <= flags_a_d;
      flags_b_q <= flags_b_d;
      flags_c_q <= flags_c_d;
      control_q <= control_d;
    end
  end

  // Answer is prepared at setup so the access phase takes one cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ready_q <= setup;
      err_q <= setup & ~mapped;
      rdata_q <= setup ? {{(DATA_W-REG_W){1'b0}}, rd_byte} : '0;
      irq_q <= irq_d;
    end
  end

  assign PRDATA = rdata_q;
  assign PREADY = ready_q;
  assign PSLVERR = err_q;
  assign PERIPH_IRQ = irq_q;
  assign PRIORITY_MODE = control_q[CTL_PRIORITY];

  a_set_beats_clear: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (wr_now && sel_fl_b && !wbyte[B_CLOCK_FAIL] && EV_B.clock_fail)
    |=> flags_b_q[B_CLOCK_FAIL])
    else $error("clock fail event lost to a clear");

  a_group_gates_irq: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !control_q[CTL_GROUP_EN] |=> !PERIPH_IRQ)
    else $error("request raised with group enable off");

  a_pending_raises_irq: assert property (
    @(posedge CLK) disable iff (!RST_B)
    ((flags_c_q[C_RTC] && enable_c_q[C_RTC]) && group_en)
    |=> PERIPH_IRQ)
    else $error("enabled pending flag gave no request");

  a_unused_bit_zero: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !flags_b_q[B_UNUSED] && !enable_b_q[B_UNUSED])
    else $error("unimplemented bit became set");

  a_timer1_sticky: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (flags_a_q[A_TIMER1] && !(wr_now && sel_fl_a))
    |=> flags_a_q[A_TIMER1])
    else $error("timer1 flag dropped without a write");

  a_comparator_change: assert property (
    @(posedge CLK) disable iff (!RST_B)
    $changed(cmp_s2_q[1]) |=> flags_b_q[B_COMPARATOR_B])
    else $error("comparator change not flagged");

  a_rx_tracks_buffer: assert property (
    @(posedge CLK) disable iff (!RST_B)
    1'b1 |=> (flags_c_q[C_UART_RX] == $past(UART_B_RX_FULL)))
    else $error("receive flag does not follow buffer");

  a_pwm_no_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (CAPCOMP_B_MODE == CC_PWM && !flags_b_q[B_CAPCOMP]
     && !(wr_now && sel_fl_b)) |=> !flags_b_q[B_CAPCOMP])
    else $error("capcomp b flag set in pulse-width mode");

  a_rtc_sets_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_C.rtc_event |=> flags_c_q[C_RTC])
    else $error("rtc event not flagged");

  a_small_no_parallel: assert property (
    @(posedge CLK) disable iff (!RST_B)
    SMALL_PACKAGE |-> !flags_a_q[A_PARALLEL] && !enable_a_q[A_PARALLEL])
    else $error("parallel port bit present on small package");

  a_apb_one_wait: assert property (
    @(posedge CLK) disable iff (!RST_B)
    setup |=> PREADY ##1 !PREADY)
    else $error("access phase not exactly one cycle");

  a_timer2_sets_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_A.timer2_match |=> flags_a_q[A_TIMER2])
    else $error("timer2 match not flagged");

  a_clock_fail_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_B.clock_fail |=> flags_b_q[B_CLOCK_FAIL])
    else $error("clock fail not flagged");

  a_collision_a_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_B.serial_a_collision |=> flags_b_q[B_COLLISION])
    else $error("serial a collision not flagged");

  a_collision_b_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_C.serial_b_collision |=> flags_c_q[C_COLLISION])
    else $error("serial b collision not flagged");

  a_voltage_sets_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_B.voltage_trip |=> flags_b_q[B_VOLTAGE])
    else $error("voltage trip not flagged");

  a_timer3_sets_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_B.timer3_overflow |=> flags_b_q[B_TIMER3])
    else $error("timer3 overflow not flagged");

  a_capcomp_sets_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (EV_B.capcomp_b && cc_b_ok) |=> flags_b_q[B_CAPCOMP])
    else $error("capcomp b event not flagged");

  a_serial_done_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_C.serial_b_done |=> flags_c_q[C_SERIAL_DONE])
    else $error("serial b completion not flagged");

  a_tx_tracks_buffer: assert property (
    @(posedge CLK) disable iff (!RST_B)
    1'b1 |=> (flags_c_q[C_UART_TX] == $past(UART_B_TX_EMPTY)))
    else $error("transmit flag does not follow buffer");

  a_timer4_sets_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_C.timer4_match |=> flags_c_q[C_TIMER4])
    else $error("timer4 match not flagged");

  a_charge_sets_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_C.charge_time |=> flags_c_q[C_CHARGE_TIME])
    else $error("charge-time event not flagged");

  a_gate_sets_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    EV_C.timer3_gate |=> flags_c_q[C_TIMER3_GATE])
    else $error("timer3 gate event not flagged");

  a_enable_a_write: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (wr_now && sel_en_a) |=> (enable_a_q == ($past(wbyte) & IMPL_A)))
    else $error("first enable register write not stored");

  a_enable_b_write: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (wr_now && sel_en_b) |=> (enable_b_q == ($past(wbyte) & IMPL_B)))
    else $error("second enable register write not stored");

  a_flag_ignores_enable: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (EV_B.timer3_overflow && !enable_b_q[B_TIMER3])
    |=> flags_b_q[B_TIMER3])
    else $error("disabled source did not set its flag");

  a_priority_group: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (control_q[CTL_PRIORITY] && !group_en) |=> !PERIPH_IRQ)
    else $error("priority mode request without group enable");

  a_write_stores_flag: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (wr_now && sel_fl_b && (set_b == 8'h00))
    |=> (flags_b_q == ($past(wbyte) & SWCLR_B)))
    else $error("flag register write not stored");

endmodule
`default_nettype wire

/* File: test/periph_events_model.sv */
// Peripheral event sources and level sources facing the flag block
`default_nettype none
module periph_events_model
  import irq_flags_pkg::*;
(
  input wire logic clk,
  output events_a_t ev_a,
  output events_b_t ev_b,
  output events_c_t ev_c,
  output logic [1:0] cmp_out,
  output logic rx_full,
  output logic tx_empty,
  output capcomp_mode_t mode_b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ev_a = '0;
    ev_b = '0;
    ev_c = '0;
    cmp_out = 2'h0;
    rx_full = 1'b0;
    tx_empty = 1'b0;
    mode_b = CC_CAPTURE;
  end
  // Sources pulse for exactly one cycle, never a held level
  task automatic pulse(input events_a_t a, input events_b_t b,
                       input events_c_t c);
    @(posedge clk);
    ev_a <= a;
    ev_b <= b;
    ev_c <= c;
    @(posedge clk);
    ev_a <= '0;
    ev_b <= '0;
    ev_c <= '0;
  endtask
  task automatic levels(input logic [1:0] cmp, input logic rx,
                        input logic tx, input capcomp_mode_t m);
    @(posedge clk);
    cmp_out <= cmp;
    rx_full <= rx;
    tx_empty <= tx;
    mode_b <= m;
  endtask
endmodule
`default_nettype wire

/* File: test/periph_irq_flags_tb.sv */
// Self-checking bench for the peripheral flag and enable block
`default_nettype none
module periph_irq_flags_tb;
  import irq_flags_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, irq, prio;
  events_a_t ev_a;
  events_b_t ev_b;
  events_c_t ev_c;
  logic [1:0] cmp_out;
  logic rx_full, tx_empty;
  capcomp_mode_t mode_b;
  int err_total = 0;
  int comparisons = 0;
  logic [DATA_W-1:0] rv;
  logic re;

  initial begin
    forever #50 clk = ~clk;
  end

  periph_events_model periph_events_model_i (.clk(clk), .ev_a(ev_a),
    .ev_b(ev_b), .ev_c(ev_c), .cmp_out(cmp_out), .rx_full(rx_full),
    .tx_empty(tx_empty), .mode_b(mode_b));

  periph_irq_flags periph_irq_flags_i (.CLK(clk), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EV_A(ev_a), .UART_A_RX_FULL(1'b0),
    .UART_A_TX_EMPTY(1'b0), .CAPCOMP_A_MODE(CC_COMPARE), .EV_B(ev_b),
    .CMP_OUT(cmp_out), .CAPCOMP_B_MODE(mode_b), .EV_C(ev_c),
    .UART_B_RX_FULL(rx_full), .UART_B_TX_EMPTY(tx_empty),
    .PERIPH_IRQ(irq), .PRIORITY_MODE(prio));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Pready is read before the edge's own updates land
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rv, {24'h0, exp});
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask

  task automatic t_reset();
    logic [IDX_W-1:0] ids [7];
    ids = '{IDX_ENABLE_A, IDX_FLAGS_A, IDX_ENABLE_B, IDX_FLAGS_B,
            IDX_ENABLE_C, IDX_FLAGS_C, IDX_CONTROL};
    foreach (ids[i]) rd(ids[i], 8'h00);
    $display("test reset done");
  endtask

  task automatic t_sticky();
    periph_events_model_i.levels(2'h3, 1'b0, 1'b0, CC_CAPTURE);
    periph_events_model_i.pulse('1, '1, '1);
    repeat (5) @(posedge clk);
    rd(IDX_FLAGS_A, 8'hCF);
    rd(IDX_FLAGS_B, 8'hEF);
    rd(IDX_FLAGS_C, 8'hCF);
    check({31'h0, irq}, 32'h0);
    rd(IDX_FLAGS_B, 8'hEF);
    wr(IDX_FLAGS_A, 8'h00);
    wr(IDX_FLAGS_B, 8'h10);
    wr(IDX_FLAGS_C, 8'h00);
    rd(IDX_FLAGS_A, 8'h00);
    rd(IDX_FLAGS_B, 8'h00);
    rd(IDX_FLAGS_C, 8'h00);
    wr(IDX_FLAGS_B, 8'h09);
    rd(IDX_FLAGS_B, 8'h09);
    wr(IDX_FLAGS_B, 8'h00);
    $display("test sticky done");
  endtask

  task automatic t_capcomp();
    periph_events_model_i.levels(2'h3, 1'b0, 1'b0, CC_PWM);
    periph_events_model_i.pulse('0, events_b_t'(5'h01), '0);
    rd(IDX_FLAGS_B, 8'h00);
    periph_events_model_i.levels(2'h3, 1'b0, 1'b0, CC_COMPARE);
    periph_events_model_i.pulse('0, events_b_t'(5'h01), '0);
    rd(IDX_FLAGS_B, 8'h01);
    wr(IDX_FLAGS_B, 8'h00);
    $display("test capcomp done");
  endtask

  task automatic t_enables();
    wr(IDX_ENABLE_A, 8'hFF);
    rd(IDX_ENABLE_A, 8'hFF);
    wr(IDX_ENABLE_B, 8'hFF);
    rd(IDX_ENABLE_B, 8'hEF);
    wr(IDX_ENABLE_A, 8'h00);
    wr(IDX_ENABLE_B, 8'h00);
    $display("test enables done");
  endtask

  task automatic t_uart();
    periph_events_model_i.levels(2'h3, 1'b1, 1'b1, CC_CAPTURE);
    wr(IDX_FLAGS_C, 8'h00);
    rd(IDX_FLAGS_C, 8'h30);
    periph_events_model_i.levels(2'h3, 1'b0, 1'b0, CC_CAPTURE);
    rd(IDX_FLAGS_C, 8'h00);
    $display("test uart done");
  endtask

  task automatic t_irq();
    wr(IDX_ENABLE_C, 8'h01);
    periph_events_model_i.pulse('0, '0, events_c_t'(6'h01));
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(IDX_CONTROL, 8'h01);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(IDX_CONTROL, 8'h02);
    repeat (2) @(posedge clk);
    check({30'h0, prio, irq}, 32'h2);
    wr(IDX_CONTROL, 8'h03);
    repeat (2) @(posedge clk);
    check({30'h0, prio, irq}, 32'h3);
    wr(IDX_FLAGS_C, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_ENABLE_C, 8'h00);
    $display("test irq done");
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'hF9F, 8'hFF);
    check({31'h0, re}, 32'h1);
    apb(1'b0, 12'hF9F, 8'h00);
    check({re, rv[30:0]}, 32'h80000000);
    $display("test unmapped done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_sticky();
    t_capcomp();
    t_enables();
    t_uart();
    t_irq();
    t_unmapped();
    end_of_test();
  end
endmodule
`default_nettype wire
